// ---- hdl/rtsc_pkg.sv ----
// shared constants, types and helpers for the reset sequencer
package rtsc_pkg;

  // timing: the power-up delay is counted on the independent rc tick
  localparam int unsigned POWERUP_TIMER_TIME_NS = 72000000;
  localparam int unsigned RC_TICK_NS_DEF = 1000;
  localparam int unsigned POWERUP_TIMER_TICKS_DEF = POWERUP_TIMER_TIME_NS / RC_TICK_NS_DEF;
  localparam int unsigned OST_OSC_PERIODS = 1024;

  // program counter
  localparam int unsigned PC_W = 13;
  localparam logic [PC_W-1:0] PC_RESET_ADDR = 13'h0000;
  localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // register indexes, byte address is four times the index
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h83;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTL = 8'h8B;
  localparam logic [IDX_W-1:0] IDX_PIRF = 8'h8C;
  localparam logic [IDX_W-1:0] IDX_POWER_CONTROL_STATUS = 8'h8E;
  localparam logic [IDX_W-1:0] IDX_OSC_TRIM = 8'h8F;
  localparam logic [IDX_W-1:0] IDX_ADC0 = 8'h9F;
  localparam logic [IDX_W-1:0] IDX_CFG = 8'hF0;
  localparam logic [IDX_W-1:0] IDX_PC = 8'hF1;

  // field positions
  localparam int unsigned POWER_CONTROL_STATUS_POR_BIT = 1;
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam int unsigned IRQ_GIE_BIT = 7;
  localparam int unsigned IRQ_INTF_BIT = 1;
  localparam int unsigned IRQ_GPIF_BIT = 0;
  localparam int unsigned PIRF_ADIF_BIT = 6;
  localparam int unsigned ADC0_GO_BIT = 3;
  localparam int unsigned CFG_POWERUP_TIMER_ENABLE_N_N_BIT = 3;
  localparam int unsigned TRIM_LSB = 2;

  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IRQ_KEEP_MASK = 8'h01;
  localparam logic [7:0] ADC0_RST = 8'h00;
  localparam logic [5:0] OSC_TRIM_RST = 6'h20;
  localparam logic [3:0] CFG_RST = 4'hC;

  // oscillator modes, bit 2 clear means a crystal mode
  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = 3'b000,
    STANDARD_CRYSTAL_MODE = 3'b001,
    HIGH_SPEED_CRYSTAL_MODE = 3'b010,
    INTERNAL_RC_MODE = 3'b100,
    INTERNAL_RC_CLKOUT_MODE = 3'b101,
    EXTERNAL_RC_MODE = 3'b110,
    EXTERNAL_RC_CLKOUT_MODE = 3'b111
  } rtsc_osc_mode_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_POWERUP_TIMER = 3'b001,
    ST_OST = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b100,
    ST_WAKE = 3'b101
  } rtsc_state_t;

  // whole state of the sequencer
  typedef struct packed {
    rtsc_state_t st;
    logic master_clear_n_q;
    logic powerup_timer_go;
    logic ost_go;
    logic por_flag;
    logic to_n;
    logic pd_n;
    logic [7:0] option;
    logic [7:0] irq;
    logic adif;
    logic [7:0] adc0;
    logic [5:0] trim;
    logic [3:0] cfg;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic core_rst_n;
    logic asleep;
  } rtsc_seq_t;

  function automatic logic rtsc_is_crystal(input logic [3:0] cfg);
    return ~cfg[2];
  endfunction

endpackage

// ---- hdl/rtsc_reg_if.sv ----
// register access path between the apb slave and the sequencer
interface rtsc_reg_if;
  import rtsc_pkg::*;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport slv (output wr, output idx, output wdata, input rdata, input hit);
  modport regs (input wr, input idx, input wdata, output rdata, output hit);
endinterface

// ---- hdl/rtsc_count.sv ----
// tick counter used for the power-up and oscillator start-up delays
module rtsc_count
  import rtsc_pkg::*;
#(
  parameter int unsigned W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // status
  output logic running
);

  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
  } rtsc_cnt_t;

  rtsc_cnt_t s_q;
  rtsc_cnt_t s_d;

  // a zero limit never starts, so the delay is simply skipped
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.busy = (limit != '0);
      s_d.cnt = '0;
    end else if (s_q.busy && tick) begin
      if (s_q.cnt == limit - W'(1)) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign running = s_q.busy;

endmodule // rtsc_count

// ---- hdl/rtsc_apb.sv ----
// apb slave front end: zero-wait answer, decode of the word index
module rtsc_apb
  import rtsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register side
  rtsc_reg_if.slv rif
);

  typedef struct packed {
    logic rdy;
    logic err;
    logic [31:0] data;
  } rtsc_apb_t;

  rtsc_apb_t s_q;
  rtsc_apb_t s_d;
  logic addr_ok;

  // only aligned words inside the index space are mapped
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && rif.hit;
  assign rif.idx = paddr[9:2];
  assign rif.wdata = pwdata;
  assign rif.wr = psel && penable && s_q.rdy && pwrite && !s_q.err;

  // answer is prepared in the setup cycle so pready can come from a flop
  always_comb begin
    s_d = s_q;
    if (psel && !penable) begin
      s_d.rdy = 1'b1;
      s_d.err = !addr_ok;
      s_d.data = (addr_ok && !pwrite) ? rif.rdata : 32'h00000000;
    end else if (psel && penable && s_q.rdy) begin
      s_d.rdy = 1'b0;
      s_d.err = 1'b0;
      s_d.data = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.data;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;

endmodule // rtsc_apb

// ---- hdl/rtsc_top.sv ----
// reset, time-out and reset-cause sequencer with its special registers
module rtsc_top
  import rtsc_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_TICKS = POWERUP_TIMER_TICKS_DEF,
  parameter int unsigned POWERUP_TIMER_W = 17,
  parameter int unsigned OST_CYCLES = OST_OSC_PERIODS,
  parameter int unsigned OST_W = 11
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // apb register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset and wake sources
  input wire logic POR_PULSE,
  input wire logic MASTER_CLEAR_N,
  input wire logic WDT_TIMEOUT,
  input wire logic [1:0] IRQ_WAKE,
  input wire logic ADC_WAKE,
  // timing ticks
  input wire logic RC_TICK,
  input wire logic OSC_TICK,
  // core side
  input wire logic SLEEP_REQ,
  input wire logic [PC_W-1:0] CORE_PC,
  output logic CORE_RESET_N,
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_VALUE,
  output logic ASLEEP
);

  // refuse counts that the counter widths cannot hold, at elaboration
  if (POWERUP_TIMER_TICKS >= (64'd1 << POWERUP_TIMER_W) || OST_CYCLES >= (64'd1 << OST_W)
      || OST_CYCLES == 0) begin : g_bad_count
    $error("rtsc_top: timer count does not fit its width");
  end

  rtsc_seq_t s_q;
  rtsc_seq_t s_d;
  rtsc_reg_if rif ();
  logic powerup_timer_run;
  logic ost_run;

  // register bus front end
  rtsc_apb u_apb (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .rif(rif)
  );

  // power-up delay counted on the independent rc tick
  rtsc_count #(.W(POWERUP_TIMER_W)) u_powerup_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .start(s_q.powerup_timer_go),
    .tick(RC_TICK),
    .limit(POWERUP_TIMER_W'(POWERUP_TIMER_TICKS)),
    .running(powerup_timer_run)
  );

  // start-up delay counted on oscillator periods
  rtsc_count #(.W(OST_W)) u_ost (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .start(s_q.ost_go),
    .tick(OSC_TICK),
    .limit(OST_W'(OST_CYCLES)),
    .running(ost_run)
  );

  // values common to power-on, master clear and watchdog resets
  function automatic rtsc_seq_t apply_reset(input rtsc_seq_t x);
    x.option = OPTION_RST;
    x.irq = x.irq & IRQ_KEEP_MASK;
    x.adif = 1'b0;
    x.adc0 = ADC0_RST;
    x.trim = OSC_TRIM_RST;
    x.pc = PC_RESET_ADDR;
    x.pc_load = 1'b1;
    return x;
  endfunction

  // leaving sleep: next address, or the vector when an enabled irq woke us
  function automatic rtsc_seq_t apply_wake(input rtsc_seq_t x, input logic vec,
                                           input logic [PC_W-1:0] pc_now);
    x.pc = vec ? PC_IRQ_VECTOR : pc_now + PC_STEP;
    x.pc_load = 1'b1;
    if (rtsc_is_crystal(x.cfg)) begin
      x.ost_go = 1'b1;
      x.st = ST_WAKE;
    end else begin
      x.st = ST_RUN;
    end
    return x;
  endfunction

  // register read decode
  always_comb begin
    rif.hit = 1'b1;
    rif.rdata = 32'h00000000;
    if (rif.idx == IDX_POWER_CONTROL_STATUS) begin
      rif.rdata[POWER_CONTROL_STATUS_POR_BIT] = s_q.por_flag;
    end else if (rif.idx == IDX_STATUS) begin
      rif.rdata[STATUS_TO_BIT] = s_q.to_n;
      rif.rdata[STATUS_PD_BIT] = s_q.pd_n;
    end else if (rif.idx == IDX_OPTION) begin
      rif.rdata[7:0] = s_q.option;
    end else if (rif.idx == IDX_IRQ_CTL) begin
      rif.rdata[7:0] = s_q.irq;
    end else if (rif.idx == IDX_PIRF) begin
      rif.rdata[PIRF_ADIF_BIT] = s_q.adif;
    end else if (rif.idx == IDX_ADC0) begin
      rif.rdata[7:0] = s_q.adc0;
    end else if (rif.idx == IDX_OSC_TRIM) begin
      rif.rdata[7:TRIM_LSB] = s_q.trim;
    end else if (rif.idx == IDX_CFG) begin
      rif.rdata[3:0] = s_q.cfg;
    end else if (rif.idx == IDX_PC) begin
      rif.rdata[PC_W-1:0] = s_q.pc;
    end else begin
      rif.hit = 1'b0;
    end
  end

  // sequencer: software writes first, hardware events after so a set wins
  always_comb begin
    logic master_clear_n_fall;
    logic wdt_reset;
    logic irq_wake;
    master_clear_n_fall = 1'b0;
    wdt_reset = 1'b0;
    irq_wake = 1'b0;
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.powerup_timer_go = 1'b0;
    s_d.ost_go = 1'b0;
    s_d.master_clear_n_q = MASTER_CLEAR_N;
    master_clear_n_fall = s_q.master_clear_n_q && !MASTER_CLEAR_N;
    irq_wake = (IRQ_WAKE != 2'b00) || ADC_WAKE;
    // software writes; status and pc are read-only
    if (rif.wr) begin
      if (rif.idx == IDX_POWER_CONTROL_STATUS) begin
        s_d.por_flag = rif.wdata[POWER_CONTROL_STATUS_POR_BIT];
      end else if (rif.idx == IDX_OPTION) begin
        s_d.option = rif.wdata[7:0];
      end else if (rif.idx == IDX_IRQ_CTL) begin
        s_d.irq = rif.wdata[7:0];
      end else if (rif.idx == IDX_PIRF) begin
        s_d.adif = rif.wdata[PIRF_ADIF_BIT];
      end else if (rif.idx == IDX_ADC0) begin
        s_d.adc0 = rif.wdata[7:0];
      end else if (rif.idx == IDX_OSC_TRIM) begin
        s_d.trim = rif.wdata[7:TRIM_LSB];
      end else if (rif.idx == IDX_CFG) begin
        s_d.cfg = rif.wdata[3:0];
      end
    end
    // reset causes in fixed precedence
    if (POR_PULSE) begin
      s_d = apply_reset(s_d);
      s_d.to_n = 1'b1;
      s_d.pd_n = 1'b1;
      s_d.por_flag = 1'b0;
      s_d.st = ST_BOOT;
    end else if (master_clear_n_fall && (s_q.st == ST_RUN || s_q.st == ST_SLEEP || s_q.st == ST_WAKE)) begin
      s_d = apply_reset(s_d);
      if (s_q.st != ST_RUN) begin
        s_d.to_n = 1'b1;
        s_d.pd_n = 1'b0;
      end
      s_d.st = ST_RUN;
    end else if (WDT_TIMEOUT && s_q.st == ST_RUN) begin
      s_d = apply_reset(s_d);
      s_d.to_n = 1'b0;
      wdt_reset = 1'b1;
    end else begin
      case (s_q.st)
        ST_BOOT: begin
          if (!s_q.cfg[CFG_POWERUP_TIMER_ENABLE_N_N_BIT]) begin
            s_d.powerup_timer_go = 1'b1;
            s_d.st = ST_POWERUP_TIMER;
          end else if (rtsc_is_crystal(s_q.cfg)) begin
            s_d.ost_go = 1'b1;
            s_d.st = ST_OST;
          end else begin
            s_d.st = ST_RUN;
          end
        end
        ST_POWERUP_TIMER: begin
          // the go pulse still sits in front of the counter for one cycle
          if (!s_q.powerup_timer_go && !powerup_timer_run) begin
            if (rtsc_is_crystal(s_q.cfg)) begin
              s_d.ost_go = 1'b1;
              s_d.st = ST_OST;
            end else begin
              s_d.st = ST_RUN;
            end
          end
        end
        ST_OST, ST_WAKE: begin
          if (!s_q.ost_go && !ost_run) begin
            s_d.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (SLEEP_REQ) begin
            s_d.pd_n = 1'b0;
            s_d.to_n = 1'b1;
            s_d.st = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (WDT_TIMEOUT) begin
            s_d.to_n = 1'b0;
            s_d.pd_n = 1'b0;
            s_d = apply_wake(s_d, 1'b0, CORE_PC);
          end else if (irq_wake) begin
            s_d.to_n = 1'b1;
            s_d.pd_n = 1'b0;
            if (IRQ_WAKE[1]) begin
              s_d.irq[IRQ_INTF_BIT] = 1'b1;
            end
            if (IRQ_WAKE[0]) begin
              s_d.irq[IRQ_GPIF_BIT] = 1'b1;
            end
            if (ADC_WAKE) begin
              s_d.adif = 1'b1;
              s_d.adc0[ADC0_GO_BIT] = 1'b0;
            end
            s_d = apply_wake(s_d, s_q.irq[IRQ_GIE_BIT], CORE_PC);
          end
        end
        default: begin
          s_d.st = ST_BOOT;
        end
      endcase
    end
    // core runs only once the time-outs are over and the pin is high
    s_d.core_rst_n = (s_d.st == ST_RUN || s_d.st == ST_SLEEP || s_d.st == ST_WAKE)
                     && MASTER_CLEAR_N && !wdt_reset;
    s_d.asleep = (s_d.st == ST_SLEEP) || (s_d.st == ST_WAKE);
  end

  // state register; cfg is a fuse image and survives a power-on event
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.st <= ST_BOOT;
      s_q.master_clear_n_q <= 1'b1; // pin idles high, so no false fall after reset
      s_q.to_n <= 1'b1;
      s_q.pd_n <= 1'b1;
      s_q.option <= OPTION_RST;
      s_q.trim <= OSC_TRIM_RST;
      s_q.cfg <= CFG_RST;
      s_q.pc <= PC_RESET_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  assign CORE_RESET_N = s_q.core_rst_n;
  assign PC_LOAD = s_q.pc_load;
  assign PC_VALUE = s_q.pc;
  assign ASLEEP = s_q.asleep;

endmodule // rtsc_top

// ---- verif/rtsc_top_assertions.sv ----
// concurrent checks on the reset sequencer's top-level ports
module rtsc_top_chk
  import rtsc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // apb answer
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // reset and wake sources
  input wire logic POR_PULSE,
  input wire logic MASTER_CLEAR_N,
  input wire logic WDT_TIMEOUT,
  input wire logic [1:0] IRQ_WAKE,
  input wire logic ADC_WAKE,
  // core side
  input wire logic CORE_RESET_N,
  input wire logic PC_LOAD,
  input wire logic [PC_W-1:0] PC_VALUE,
  input wire logic ASLEEP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // a running watchdog bite resets the core for one cycle only
  wdt_run_a:
  assert property (WDT_TIMEOUT && CORE_RESET_N && !ASLEEP && MASTER_CLEAR_N && !POR_PULSE
    |=> !CORE_RESET_N && PC_LOAD && PC_VALUE == PC_RESET_ADDR ##1 CORE_RESET_N)
    else $error("watchdog reset not one cycle at zero");
  por_load_a:
  assert property (POR_PULSE |=> PC_LOAD && PC_VALUE == PC_RESET_ADDR && !CORE_RESET_N)
    else $error("power-on did not load zero");
  master_clear_n_load_a:
  assert property ($fell(MASTER_CLEAR_N) && !POR_PULSE && CORE_RESET_N
    |=> PC_LOAD && PC_VALUE == PC_RESET_ADDR)
    else $error("master clear did not load zero");
  master_clear_n_hold_a:
  assert property (!MASTER_CLEAR_N |=> !CORE_RESET_N)
    else $error("core runs with master clear low");
  // wakes resume rather than restart, possibly after the start-up delay
  wake_load_a:
  assert property (ASLEEP && !POR_PULSE && MASTER_CLEAR_N
    && (WDT_TIMEOUT || ADC_WAKE || IRQ_WAKE != 2'b00)
    |-> ##[1:300] PC_LOAD && PC_VALUE != PC_RESET_ADDR)
    else $error("wake did not resume");
  run_gate_a:
  assert property ($rose(CORE_RESET_N) |-> $past(MASTER_CLEAR_N))
    else $error("core released while pin low");
  apb_ready_a:
  assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb answer not in first access cycle");
  apb_slverr_a:
  assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer carries data");
  pc_load_pulse_a:
  assert property (PC_LOAD |=> !PC_LOAD)
    else $error("pc load longer than a cycle");
endmodule // rtsc_top_chk

bind rtsc_top rtsc_top_chk u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .POR_PULSE(POR_PULSE), .MASTER_CLEAR_N(MASTER_CLEAR_N), .WDT_TIMEOUT(WDT_TIMEOUT),
  .IRQ_WAKE(IRQ_WAKE), .ADC_WAKE(ADC_WAKE), .CORE_RESET_N(CORE_RESET_N),
  .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .ASLEEP(ASLEEP));

// ---- verif/rtsc_core_model.sv ----
// core stand-in: steps its program counter while running, obeys loads
module rtsc_core_model
  import rtsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // from the sequencer
  input wire logic core_reset_n,
  input wire logic asleep,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  // bench command to execute a sleep
  input wire logic sleep_cmd,
  // to the sequencer
  output logic sleep_req,
  output logic [PC_W-1:0] core_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // pc freezes once sleep is asked, so the wake address is well defined
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_req <= 1'b0;
      core_pc <= PC_RESET_ADDR;
    end else begin
      sleep_req <= sleep_cmd && core_reset_n && !asleep;
      if (pc_load) begin
        core_pc <= pc_value;
      end else if (core_reset_n && !asleep && !sleep_req) begin
        core_pc <= core_pc + PC_STEP;
      end
    end
  end
endmodule // rtsc_core_model

// ---- verif/rtsc_top_tb.sv ----
// self-checking bench for the reset sequencer
`define CHK(nm, x, g) begin samples_checked++; if ((g) !== (x)) begin miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, x, g); end end
module rtsc_top_tb;
  import rtsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} rtsc_rd_t;
  logic SYS_CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, POR_PULSE = 0;
  logic MASTER_CLEAR_N = 1, WDT_TIMEOUT = 0, ADC_WAKE = 0, RC_TICK = 0, OSC_TICK = 0;
  logic [1:0] IRQ_WAKE = 0;
  logic [1:0] t = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA;
  logic PREADY, PSLVERR, CORE_RESET_N, PC_LOAD, ASLEEP, SLEEP_REQ, go_sleep = 0;
  logic [PC_W-1:0] CORE_PC, PC_VALUE;
  logic [7:0] r;
  logic [4:0] wake [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
  logic [7:0] irqx [4] = '{8'h01, 8'h82, 8'h00, 8'h00};
  rtsc_rd_t rdq[$];
  rtsc_rd_t e;
  logic [PC_W-1:0] pe;
  logic [PC_W-1:0] pcq[$];
  int miscompares = 0, samples_checked = 0, n, lo;

  always #2 SYS_CLK = ~SYS_CLK;
  // rc tick every 4 cycles, oscillator tick every 2
  always @(posedge SYS_CLK) begin
    t <= t + 2'd1;
    RC_TICK <= (t == 2'd0);
    OSC_TICK <= t[0];
  end

  rtsc_top #(.POWERUP_TIMER_TICKS(5), .OST_CYCLES(4)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .POR_PULSE(POR_PULSE),
    .MASTER_CLEAR_N(MASTER_CLEAR_N), .WDT_TIMEOUT(WDT_TIMEOUT), .IRQ_WAKE(IRQ_WAKE),
    .ADC_WAKE(ADC_WAKE), .RC_TICK(RC_TICK), .OSC_TICK(OSC_TICK), .SLEEP_REQ(SLEEP_REQ),
    .CORE_PC(CORE_PC), .CORE_RESET_N(CORE_RESET_N), .PC_LOAD(PC_LOAD),
    .PC_VALUE(PC_VALUE), .ASLEEP(ASLEEP));
  rtsc_core_model core (.clk(SYS_CLK), .rst_b(RST_B), .core_reset_n(CORE_RESET_N),
    .asleep(ASLEEP), .pc_load(PC_LOAD), .pc_value(PC_VALUE), .sleep_cmd(go_sleep),
    .sleep_req(SLEEP_REQ), .core_pc(CORE_PC));

  // results are matched oldest-first against what the driver promised
  always @(posedge SYS_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      e = rdq.pop_front();
      `CHK("prdata", e.v, PRDATA & e.m)
      `CHK("pslverr", e.e, PSLVERR)
    end
    // pop once: the macro names its expected value twice
    if (PC_LOAD === 1'b1) begin
      pe = pcq.pop_front();
      `CHK("pc_value", pe, PC_VALUE)
    end
  end

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {2'b00, i, 2'b00};
    PWDATA <= d;
    @(posedge SYS_CLK) PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] v, input logic [31:0] m,
                    input logic er = 1'b0);
    rdq.push_back('{v, m, er});
    apb(1'b0, i, 32'h0);
  endtask
  // one-cycle event pulse on {por, watchdog, conversion, irq[1:0]}
  task automatic kick(input logic [4:0] k);
    {POR_PULSE, WDT_TIMEOUT, ADC_WAKE, IRQ_WAKE} <= k;
    @(posedge SYS_CLK) {POR_PULSE, WDT_TIMEOUT, ADC_WAKE, IRQ_WAKE} <= 5'h00;
    @(posedge SYS_CLK);
  endtask
  task automatic run_wait;
    n = 0;
    while (!(CORE_RESET_N === 1'b1 && ASLEEP === 1'b0) && n < 300) begin
      @(posedge SYS_CLK);
      n++;
    end
    `CHK("run_wait", 1'b1, n < 300)
  endtask
  task automatic master_clear_n;
    MASTER_CLEAR_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    MASTER_CLEAR_N <= 1'b1;
    run_wait;
  endtask
  task automatic nap;
    go_sleep <= 1'b1;
    @(posedge SYS_CLK) go_sleep <= 1'b0;
    while (ASLEEP !== 1'b1) @(posedge SYS_CLK);
    rd(IDX_STATUS, 8'h10, 8'h18);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  initial begin
    #80000;
    miscompares++;
    print_verdict;
  end

  initial begin
    n = $urandom(88);
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    rd(IDX_POWER_CONTROL_STATUS, 8'h00, 8'h02);
    rd(IDX_STATUS, 8'h18, 8'h18);
    rd(IDX_OPTION, 8'hFF, 8'hFF);
    rd(IDX_IRQ_CTL, 8'h00, 8'h80);
    rd(IDX_OSC_TRIM, 8'h80, 8'hFC);
    rd(8'h55, 32'h0, 32'hFFFFFFFF, 1'b1);
    run_wait;
    apb(1'b1, IDX_POWER_CONTROL_STATUS, 8'h02);
    rd(IDX_POWER_CONTROL_STATUS, 8'h02, 8'h02);
    $display("test defaults done");
    pcq.push_back(PC_RESET_ADDR);
    kick(5'h08);
    run_wait;
    rd(IDX_STATUS, 8'h08, 8'h18);
    r = 8'($urandom);
    apb(1'b1, IDX_OPTION, r);
    apb(1'b1, IDX_IRQ_CTL, 8'h80);
    apb(1'b1, IDX_OSC_TRIM, 8'h44);
    pcq.push_back(PC_RESET_ADDR);
    master_clear_n;
    rd(IDX_STATUS, 8'h08, 8'h18);
    rd(IDX_POWER_CONTROL_STATUS, 8'h02, 8'h02);
    rd(IDX_OPTION, 8'hFF, 8'hFF);
    rd(IDX_IRQ_CTL, 8'h00, 8'h80);
    rd(IDX_OSC_TRIM, 8'h80, 8'hFC);
    rd(IDX_PC, PC_RESET_ADDR, 32'h00001FFF);
    $display("test run resets done");
    // pin irq, external irq with vector, conversion, watchdog
    for (int k = 0; k < 4; k++) begin
      r = 8'($urandom);
      apb(1'b1, IDX_OPTION, r);
      apb(1'b1, IDX_IRQ_CTL, (k == 1) ? 8'h80 : 8'h00);
      apb(1'b1, IDX_ADC0, 8'h08);
      nap;
      pcq.push_back((k == 1) ? PC_IRQ_VECTOR : CORE_PC + PC_STEP);
      kick(wake[k]);
      run_wait;
      rd(IDX_STATUS, (k == 3) ? 8'h00 : 8'h10, 8'h18);
      rd(IDX_IRQ_CTL, irqx[k], 8'h83);
      rd(IDX_PIRF, (k >= 2) ? 8'h40 : 8'h00, 8'h40);
      rd(IDX_ADC0, (k == 2) ? 8'h00 : 8'h08, 8'h08);
      rd(IDX_OPTION, r, 8'hFF);
    end
    nap;
    pcq.push_back(PC_RESET_ADDR);
    master_clear_n;
    rd(IDX_STATUS, 8'h10, 8'h18);
    rd(IDX_POWER_CONTROL_STATUS, 8'h02, 8'h02);
    apb(1'b1, IDX_CFG, 8'h09);
    nap;
    pcq.push_back(CORE_PC + PC_STEP);
    kick(5'h01);
    run_wait;
    `CHK("wake_cycles", 1'b1, n >= 4 && n <= 20)
    $display("test sleep and wake done");
    // power-on in every oscillator mode, timer on for even m and off for odd m
    for (int m = 0; m < 8; m++) begin
      if (m != 3) begin
        apb(1'b1, IDX_CFG, {m[0], m[2:0]});
        pcq.push_back(PC_RESET_ADDR);
        kick(5'h18);
        run_wait;
        lo = (m[0] ? 0 : 16) + (m[2] ? 0 : 6);
        `CHK("startup_cycles", 1'b1, n >= lo && n <= lo + 14)
        rd(IDX_POWER_CONTROL_STATUS, 8'h00, 8'h02);
        rd(IDX_STATUS, 8'h18, 8'h18);
        apb(1'b1, IDX_POWER_CONTROL_STATUS, 8'h02);
      end
    end
    // pin held low through the delays: core starts right on release
    apb(1'b1, IDX_CFG, 8'h00);
    pcq.push_back(PC_RESET_ADDR);
    kick(5'h10);
    MASTER_CLEAR_N <= 1'b0;
    repeat (60) @(posedge SYS_CLK);
    `CHK("held_by_pin", 1'b0, CORE_RESET_N)
    MASTER_CLEAR_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    `CHK("run_on_release", 1'b1, CORE_RESET_N)
    $display("test power-on modes done");
    print_verdict;
  end
endmodule // rtsc_top_tb
